// ===== rtl/sdram_map.svh
// Command codes, mode field positions and timing constants
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH

// Command code is {row strobe, column strobe, write strobe}, active low
`define CMD_MODE_SET        3'h0
`define CMD_REFRESH         3'h1
`define CMD_PRECHARGE       3'h2
`define CMD_ACTIVATE        3'h3
`define CMD_WRITE           3'h4
`define CMD_READ            3'h5
`define CMD_BURST_STOP      3'h6
`define CMD_NOP             3'h7

`define MODE_BL_LSB         0
`define MODE_BL_MSB         2
`define MODE_ORDER_BIT      3
`define MODE_LAT_LSB        4
`define MODE_LAT_MSB        6
`define MODE_SINGLE_WR_BIT  9
`define MODE_RESET          12'h020
`define BL_FULL_PAGE        3'h7
`define LAT_THREE           3'h3
`define FULL_PAGE_BEATS     9'h100

`define COL_MSB             7
`define PRECHARGE_ALL_BIT   10

`define CLK_PERIOD_NS       10
`define REFRESH_WINDOW_NS   64000000
`define REFRESH_ROWS        4096
`define REFRESH_CYCLES      \
   (`REFRESH_WINDOW_NS / `REFRESH_ROWS / `CLK_PERIOD_NS)

`endif

// ===== rtl/sdram_pkg.sv
// Types for the ends of the memory link: commands for the controller, burst and low power states for the device
`include "sdram_map.svh"
package sdram_pkg;
   typedef enum logic [2:0] {
      CMD_MODE_SET   = `CMD_MODE_SET,
      CMD_REFRESH    = `CMD_REFRESH,
      CMD_PRECHARGE  = `CMD_PRECHARGE,
      CMD_ACTIVATE   = `CMD_ACTIVATE,
      CMD_WRITE      = `CMD_WRITE,
      CMD_READ       = `CMD_READ,
      CMD_BURST_STOP = `CMD_BURST_STOP,
      CMD_NOP        = `CMD_NOP
   } cmd_t;

   typedef enum logic [1:0] {
      BURST_IDLE  = 2'h0,
      BURST_READ  = 2'h1,
      BURST_WRITE = 2'h3
   } burst_t;

   typedef enum logic [1:0] {
      LP_NONE         = 2'h0,
      LP_POWER_DOWN   = 2'h1,
      LP_SUSPEND      = 2'h3,
      LP_SELF_REFRESH = 2'h2
   } low_power_t;
endpackage : sdram_pkg

// ===== rtl/sdram_link_if.sv
// Pin-level link between memory controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if;
   logic        clk_gate;
   logic        chip_sel_n;
   logic        row_strobe_n;
   logic        col_strobe_n;
   logic        write_strobe_n;
   logic        bank_select_line;
   logic [10:0] row_address_lines;
   logic        low_byte_mask;
   logic        high_byte_mask;
   logic [15:0] ctl_dq_out;
   logic        ctl_dq_oe;
   logic [15:0] dev_dq_out;
   logic [1:0]  dev_dq_oe;
   logic [15:0] data_bus_lines;

   // Undriven lanes read as zero
   assign data_bus_lines[7:0] = dev_dq_oe[0] ? dev_dq_out[7:0] :
                                ctl_dq_oe ? ctl_dq_out[7:0] : 8'h00;
   assign data_bus_lines[15:8] = dev_dq_oe[1] ? dev_dq_out[15:8] :
                                 ctl_dq_oe ? ctl_dq_out[15:8] : 8'h00;

   modport device (
      input  clk_gate, chip_sel_n, row_strobe_n, col_strobe_n,
      input  write_strobe_n, bank_select_line, row_address_lines,
      input  low_byte_mask, high_byte_mask, data_bus_lines,
      output dev_dq_out, dev_dq_oe
   );
   modport controller (
      output clk_gate, chip_sel_n, row_strobe_n, col_strobe_n,
      output write_strobe_n, bank_select_line, row_address_lines,
      output low_byte_mask, high_byte_mask, ctl_dq_out, ctl_dq_oe,
      input  data_bus_lines
   );
endinterface : sdram_link_if
`default_nettype wire

// ===== rtl/sdram_device.sv
// Two-bank 16-bit synchronous DRAM device model
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"
module sdram_device (
   input  wire logic                i_mclk,
   input  wire logic                i_sys_rst,
   sdram_link_if.device             link,
   output logic [1:0]               o_rows_open,
   output sdram_pkg::low_power_t    o_low_power,
   output logic [11:0]              o_mode
);
   localparam int BANKS = 2;

   logic                  gate_meta;
   logic                  gate_sync;
   logic [11:0]           mode_reg;
   logic [BANKS-1:0]      row_open;
   logic [10:0]           open_row [BANKS];
   sdram_pkg::burst_t     burst_state;
   logic                  burst_bank;
   logic [7:0]            burst_base;
   logic [8:0]            beat_cnt;
   logic [8:0]            beat_total;
   logic                  burst_auto_pre;
   sdram_pkg::low_power_t low_mode;
   logic                  pipe2_valid;
   logic [1:0]            pipe2_mask;
   logic [15:0]           pipe2_data;
   logic                  pipe1_valid;
   logic [1:0]            pipe1_mask;
   logic [15:0]           pipe1_data;
   logic                  out_valid;
   logic [1:0]            out_mask;
   logic [15:0]           out_data;
   logic [15:0]           mem [0:2*524288-1];

   // Clock gate may change at any time, so two flops first
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         gate_meta <= 1'b0;
         gate_sync <= 1'b0;
      end else begin
         gate_meta <= link.clk_gate;
         gate_sync <= gate_meta;
      end
   end

   wire        edge_ok = gate_sync;
   wire [2:0]  cmd_code = {link.row_strobe_n, link.col_strobe_n,
                           link.write_strobe_n};
   wire        cmd_sel = edge_ok & ~link.chip_sel_n;
   wire        is_mode = cmd_sel & (cmd_code == `CMD_MODE_SET);
   wire        is_act = cmd_sel & (cmd_code == `CMD_ACTIVATE);
   wire        is_rd = cmd_sel & (cmd_code == `CMD_READ);
   wire        is_wr = cmd_sel & (cmd_code == `CMD_WRITE);
   wire        is_pre = cmd_sel & (cmd_code == `CMD_PRECHARGE);
   wire        is_stop = cmd_sel & (cmd_code == `CMD_BURST_STOP);
   wire        is_refresh_raw = ~link.chip_sel_n &
                                (cmd_code == `CMD_REFRESH);
   wire        bank_in = link.bank_select_line;
   wire [7:0]  column_address_lines =
                  link.row_address_lines[`COL_MSB:0];
   wire        precharge_all_line =
                  link.row_address_lines[`PRECHARGE_ALL_BIT];
   wire [11:0] mode_operation_code =
                  {link.bank_select_line, link.row_address_lines};

   // Mode fields
   wire [2:0]  bl_code = mode_reg[`MODE_BL_MSB:`MODE_BL_LSB];
   wire        full_page = (bl_code == `BL_FULL_PAGE);
   wire [8:0]  bl_beats = full_page ? `FULL_PAGE_BEATS :
                          (9'h001 << bl_code[1:0]);
   wire        single_wr = mode_reg[`MODE_SINGLE_WR_BIT];
   wire        lat_three =
                  (mode_reg[`MODE_LAT_MSB:`MODE_LAT_LSB] == `LAT_THREE);
   wire        interleave = mode_reg[`MODE_ORDER_BIT] & ~full_page;
   wire [8:0]  wr_beats = single_wr ? 9'h001 : bl_beats;

   // Current beat: a new column command always takes over
   wire        start = is_rd | is_wr;
   wire        pre_hits = is_pre &
                  (precharge_all_line | (bank_in == burst_bank));
   wire        stop_now = is_stop | pre_hits;
   wire        continuing = (burst_state != sdram_pkg::BURST_IDLE) &
                            edge_ok & ~stop_now;
   wire        beat_now = start | continuing;
   wire        beat_write = start ? is_wr :
                            (burst_state == sdram_pkg::BURST_WRITE);
   wire        beat_bank = start ? bank_in : burst_bank;
   wire [7:0]  base = start ? column_address_lines : burst_base;
   wire [8:0]  n = start ? 9'h000 : beat_cnt;
   wire [8:0]  total = start ? (is_wr ? wr_beats : bl_beats) : beat_total;
   wire [7:0]  len_mask = total[7:0] - 8'h01;
   wire [7:0]  seq_col = (base & ~len_mask) |
                         ((base + n[7:0]) & len_mask);
   wire [7:0]  intl_col = (base & ~len_mask) | ((base ^ n[7:0]) & len_mask);
   wire [7:0]  beat_col = interleave ? intl_col : seq_col;
   wire [19:0] beat_addr = {beat_bank, open_row[beat_bank], beat_col};
   wire        last_beat = ((n + 9'h001) == total);
   wire        auto_pre = start ? precharge_all_line : burst_auto_pre;
   wire [15:0] rd_word = mem[beat_addr];
   wire        rd_beat = beat_now & ~beat_write;
   wire        wr_beat = beat_now & beat_write;

   // Row state per bank
   generate
      for (genvar b = 0; b < BANKS; b++) begin : g_bank
         wire hit = (bank_in == 1'(b));
         wire ap_close = beat_now & last_beat & auto_pre &
                         (beat_bank == 1'(b));
         always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
               row_open[b] <= 1'b0;
               open_row[b] <= 11'h000;
            end else if (is_act & hit) begin
               row_open[b] <= 1'b1;
               open_row[b] <= link.row_address_lines;
            end else if ((is_pre & (precharge_all_line | hit)) | ap_close)
            begin
               row_open[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // Burst engine
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         burst_state <= sdram_pkg::BURST_IDLE;
         burst_bank <= 1'b0;
         burst_base <= 8'h00;
         beat_cnt <= 9'h000;
         beat_total <= 9'h000;
         burst_auto_pre <= 1'b0;
      end else if (edge_ok) begin
         if (start) begin
            burst_bank <= bank_in;
            burst_base <= column_address_lines;
            beat_total <= total;
            burst_auto_pre <= precharge_all_line;
         end
         if (beat_now & ~last_beat) begin
            beat_cnt <= n + 9'h001;
            burst_state <= beat_write ? sdram_pkg::BURST_WRITE :
                                        sdram_pkg::BURST_READ;
         end else begin
            burst_state <= sdram_pkg::BURST_IDLE;
         end
      end
   end

   // Mode register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mode_reg <= `MODE_RESET;
      end else if (is_mode) begin
         mode_reg <= mode_operation_code;
      end
   end

   // Byte-masked array write; masked lanes keep their old value
   always_ff @(posedge i_mclk) begin
      if (wr_beat & ~link.low_byte_mask) begin
         mem[beat_addr][7:0] <= link.data_bus_lines[7:0];
      end
      if (wr_beat & ~link.high_byte_mask) begin
         mem[beat_addr][15:8] <= link.data_bus_lines[15:8];
      end
   end

   // Read pipeline; a three-clock latency enters one stage earlier.
   // Everything holds on ignored edges, which gives clock suspend.
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pipe2_valid <= 1'b0;
         pipe2_mask <= 2'h0;
         pipe2_data <= 16'h0000;
         pipe1_valid <= 1'b0;
         pipe1_mask <= 2'h0;
         pipe1_data <= 16'h0000;
         out_valid <= 1'b0;
         out_mask <= 2'h0;
         out_data <= 16'h0000;
      end else if (edge_ok) begin
         pipe2_valid <= rd_beat & lat_three;
         pipe2_mask <= {link.high_byte_mask, link.low_byte_mask};
         pipe2_data <= rd_word;
         if (rd_beat & ~lat_three) begin
            pipe1_valid <= 1'b1;
            pipe1_mask <= {link.high_byte_mask, link.low_byte_mask};
            pipe1_data <= rd_word;
         end else begin
            pipe1_valid <= pipe2_valid;
            pipe1_mask <= pipe2_mask;
            pipe1_data <= pipe2_data;
         end
         out_valid <= pipe1_valid;
         out_mask <= pipe1_mask;
         out_data <= pipe1_data;
      end
   end

   // Low power mode is chosen on the first ignored edge
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         low_mode <= sdram_pkg::LP_NONE;
      end else if (edge_ok) begin
         low_mode <= sdram_pkg::LP_NONE;
      end else if (low_mode == sdram_pkg::LP_NONE) begin
         if (is_refresh_raw) begin
            low_mode <= sdram_pkg::LP_SELF_REFRESH;
         end else if (burst_state != sdram_pkg::BURST_IDLE) begin
            low_mode <= sdram_pkg::LP_SUSPEND;
         end else begin
            low_mode <= sdram_pkg::LP_POWER_DOWN;
         end
      end
   end

   assign link.dev_dq_out = out_data;
   assign link.dev_dq_oe = {2{out_valid}} & ~out_mask;
   assign o_rows_open = row_open;
   assign o_low_power = low_mode;
   assign o_mode = mode_reg;
endmodule : sdram_device
`default_nettype wire

// ===== rtl/sdram_controller.sv
// Memory controller end that drives the device pins
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"
module sdram_controller (
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_clk_gate,
   input  wire logic             i_cmd_valid,
   input  wire sdram_pkg::cmd_t  i_cmd,
   input  wire logic             i_bank,
   input  wire logic [10:0]      i_addr,
   input  wire logic             i_wdata_valid,
   input  wire logic [15:0]      i_wdata,
   input  wire logic [1:0]       i_byte_mask,
   output logic                  o_ready,
   output logic [15:0]           o_rdata,
   output logic                  o_rdata_valid,
   output logic                  o_refresh_busy,
   sdram_link_if.controller      link
);
   localparam logic [11:0] REF_LAST = 12'(`REFRESH_CYCLES - 1);

   logic [11:0]     ref_cnt;
   logic            ref_pending;
   logic            ref_phase;
   logic            lat_three;
   logic [8:0]      read_beats;
   logic [3:0]      rd_line;
   logic [8:0]      beats_left;
   sdram_pkg::cmd_t pin_cmd;
   logic            pin_sel_n;
   logic            pin_bank;
   logic [10:0]     pin_addr;

   wire take = i_cmd_valid & o_ready;
   wire ref_due = (ref_cnt == REF_LAST);
   wire [2:0] bl_code = i_addr[`MODE_BL_MSB:`MODE_BL_LSB];
   wire issued_rd = take & (i_cmd == sdram_pkg::CMD_READ);
   wire stop_rd = take & ((i_cmd == sdram_pkg::CMD_BURST_STOP) |
                          (i_cmd == sdram_pkg::CMD_PRECHARGE));
   wire first_beat = lat_three ? rd_line[3] : rd_line[2];
   // Burst stop, write, the refresh precharge and every precharge cut the count; all but a precharge of the other bank end the device burst one edge
   // later, so the beat count is cut at issue time, before the first word returns
   wire cut_rd = stop_rd | (take & (i_cmd == sdram_pkg::CMD_WRITE)) |
                 (ref_pending & ~ref_phase);
   wire issued_beat = issued_rd | ((beats_left != 9'h000) & ~cut_rd);

   assign o_ready = ~ref_pending;
   assign o_refresh_busy = ref_pending;

   // Refresh pacing: precharge all, then refresh, once per period
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ref_cnt <= 12'h000;
         ref_pending <= 1'b0;
         ref_phase <= 1'b0;
      end else begin
         ref_cnt <= ref_due ? 12'h000 : ref_cnt + 12'h001;
         if (ref_due) begin
            ref_pending <= 1'b1;
         end else if (ref_pending & ref_phase) begin
            ref_pending <= 1'b0;
         end
         ref_phase <= ref_pending & ~ref_phase;
      end
   end

   // Pin drive, all registered
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pin_cmd <= sdram_pkg::CMD_NOP;
         pin_sel_n <= 1'b1;
         pin_bank <= 1'b0;
         pin_addr <= 11'h000;
      end else if (ref_pending) begin
         pin_cmd <= ref_phase ? sdram_pkg::CMD_REFRESH :
                                sdram_pkg::CMD_PRECHARGE;
         pin_sel_n <= 1'b0;
         pin_addr <= 11'h400; // Precharge-all flag set
      end else begin
         pin_cmd <= take ? i_cmd : sdram_pkg::CMD_NOP;
         pin_sel_n <= ~take;
         pin_bank <= i_bank;
         pin_addr <= i_addr;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         link.clk_gate <= 1'b0;
         link.low_byte_mask <= 1'b1;
         link.high_byte_mask <= 1'b1;
         link.ctl_dq_out <= 16'h0000;
         link.ctl_dq_oe <= 1'b0;
      end else begin
         link.clk_gate <= i_clk_gate;
         link.low_byte_mask <= i_byte_mask[0];
         link.high_byte_mask <= i_byte_mask[1];
         link.ctl_dq_out <= i_wdata;
         link.ctl_dq_oe <= i_wdata_valid & take;
      end
   end

   // Track programmed latency and burst length for read capture
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         lat_three <= 1'b0;
         read_beats <= 9'h001;
      end else if (take & (i_cmd == sdram_pkg::CMD_MODE_SET)) begin
         lat_three <=
            (i_addr[`MODE_LAT_MSB:`MODE_LAT_LSB] == `LAT_THREE);
         read_beats <= (bl_code == `BL_FULL_PAGE) ? `FULL_PAGE_BEATS :
                       (9'h001 << bl_code[1:0]);
      end
   end

   // Read capture at programmed latency
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rd_line <= 4'h0;
         beats_left <= 9'h000;
         o_rdata <= 16'h0000;
         o_rdata_valid <= 1'b0;
      end else begin
         rd_line <= {rd_line[2:0], issued_beat};
         o_rdata <= link.data_bus_lines;
         o_rdata_valid <= first_beat;
         if (issued_rd) begin
            beats_left <= read_beats - 9'h001;
         end else if (beats_left != 9'h000) begin
            beats_left <= cut_rd ? 9'h000 : beats_left - 9'h001;
         end
      end
   end

   assign link.chip_sel_n = pin_sel_n;
   assign {link.row_strobe_n, link.col_strobe_n, link.write_strobe_n} =
      pin_cmd;
   assign link.bank_select_line = pin_bank;
   assign link.row_address_lines = pin_addr;
endmodule : sdram_controller
`default_nettype wire

// ===== verification/sdram_link_sva.sv
// Protocol checks on the link between controller and device
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"
module sdram_link_sva (
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire logic        clk_gate,
   input wire logic        chip_sel_n,
   input wire logic        row_strobe_n,
   input wire logic        col_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic [10:0] row_address_lines,
   input wire logic        low_byte_mask,
   input wire logic        high_byte_mask,
   input wire logic        ctl_dq_oe,
   input wire logic [1:0]  dev_dq_oe
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   wire [2:0] cmd  = {row_strobe_n, col_strobe_n, write_strobe_n};
   wire       live = !chip_sel_n && clk_gate;
   wire       pall = live && cmd == `CMD_PRECHARGE &&
                     row_address_lines[`PRECHARGE_ALL_BIT];

   // Device synchroniser needs the gate high for a few edges
   sequence s_gated;
      clk_gate && $past(clk_gate) && $past(clk_gate, 2);
   endsequence
   sequence s_read;
      s_gated ##0 (live && cmd == `CMD_READ);
   endsequence
   sequence s_write;
      live && cmd == `CMD_WRITE;
   endsequence

   a_bus_no_clash: assert property (
      !(ctl_dq_oe && dev_dq_oe != 2'b00))
      else $error("both ends drive the data bus");
   a_read_drives: assert property (
      s_read |-> ##[2:3] (dev_dq_oe != 2'b00 ||
                         (low_byte_mask && high_byte_mask)))
      else $error("read data not driven within latency");
   a_write_takes_bus: assert property (
      s_write |-> ctl_dq_oe && dev_dq_oe == 2'b00)
      else $error("write beat without controller data");
   a_reset_quiet: assert property (
      $fell(i_sys_rst) |-> chip_sel_n && cmd == `CMD_NOP && !clk_gate &&
                          !ctl_dq_oe && low_byte_mask && high_byte_mask)
      else $error("link not idle after reset");
   a_cmd_selects: assert property (
      cmd != `CMD_NOP |-> !chip_sel_n)
      else $error("command strobes without chip select");
   a_refresh_after_pall: assert property (
      live && cmd == `CMD_REFRESH |-> $past(pall) || $past(pall, 2))
      else $error("refresh without precharge of both banks");
   a_low_lane_off: assert property (
      low_byte_mask [*4] |-> !dev_dq_oe[0])
      else $error("masked low byte driven");
   a_high_lane_off: assert property (
      high_byte_mask [*4] |-> !dev_dq_oe[1])
      else $error("masked high byte driven");
endmodule : sdram_link_sva
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench driving the controller user port against the device
`timescale 1ns/1ps
`default_nettype none
`include "sdram_map.svh"
`define CHECK_EQ(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("BAD t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module tb_top;
   logic                  i_mclk, i_sys_rst, i_clk_gate, i_cmd_valid;
   sdram_pkg::cmd_t       i_cmd;
   logic                  i_bank, i_wdata_valid;
   logic [10:0]           i_addr;
   logic [15:0]           i_wdata, o_rdata;
   logic [1:0]            i_byte_mask, o_rows_open;
   logic                  o_ready, o_rdata_valid, o_refresh_busy;
   sdram_pkg::low_power_t o_low_power;
   logic [11:0]           o_mode;
   int                    fail_count = 0, samples_checked = 0;
   int                    cyc = 0, k, k0, n;
   logic [15:0]           beats[$];
   int                    bcyc[$];

   sdram_link_if u_link ();
   sdram_controller u_sdram_controller (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_clk_gate(i_clk_gate),
      .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_bank(i_bank),
      .i_addr(i_addr), .i_wdata_valid(i_wdata_valid), .i_wdata(i_wdata),
      .i_byte_mask(i_byte_mask), .o_ready(o_ready), .o_rdata(o_rdata),
      .o_rdata_valid(o_rdata_valid), .o_refresh_busy(o_refresh_busy),
      .link(u_link));
   sdram_device u_sdram_device (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .link(u_link), .o_rows_open(o_rows_open),
      .o_low_power(o_low_power), .o_mode(o_mode));
   sdram_link_sva u_sdram_link_sva (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .clk_gate(u_link.clk_gate),
      .chip_sel_n(u_link.chip_sel_n), .row_strobe_n(u_link.row_strobe_n),
      .col_strobe_n(u_link.col_strobe_n),
      .write_strobe_n(u_link.write_strobe_n),
      .row_address_lines(u_link.row_address_lines),
      .low_byte_mask(u_link.low_byte_mask),
      .high_byte_mask(u_link.high_byte_mask),
      .ctl_dq_oe(u_link.ctl_dq_oe), .dev_dq_oe(u_link.dev_dq_oe));

   initial i_mclk = 1'b0;
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;
   // Beats are sampled mid-cycle, where the one-cycle pulse is settled
   always @(negedge i_mclk) begin
      if (o_rdata_valid === 1'b1) begin
         beats.push_back(o_rdata);
         bcyc.push_back(cyc);
      end
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Holds the request until an edge that sees the controller ready
   task automatic issue(input sdram_pkg::cmd_t c, input logic b,
                        input logic [10:0] a, input logic [15:0] d,
                        input logic [1:0] m);
      int  t;
      logic ok;
      i_cmd_valid <= 1'b1;
      i_cmd <= c;
      i_bank <= b;
      i_addr <= a;
      i_wdata_valid <= (c == sdram_pkg::CMD_WRITE);
      i_wdata <= d;
      i_byte_mask <= m;
      t = 0;
      ok = 1'b0;
      while (!ok) begin
         @(negedge i_mclk);
         ok = (o_ready === 1'b1);
         @(posedge i_mclk);
         t++;
         if (t > 20) begin
            fail_count++;
            stop_test();
         end
      end
      k = cyc;
   endtask : issue

   task automatic idle(input int c);
      i_cmd_valid <= 1'b0;
      i_wdata_valid <= 1'b0;
      repeat (c) @(posedge i_mclk);
   endtask : idle

   task automatic chk_state(input logic [1:0] rows, input logic [11:0] mode,
                            input sdram_pkg::low_power_t lp);
      @(negedge i_mclk);
      `CHECK_EQ(o_rows_open, rows)
      `CHECK_EQ(o_mode, mode)
      `CHECK_EQ(o_low_power, lp)
      @(posedge i_mclk);
   endtask : chk_state

   task automatic chk_read(input logic [15:0] e [4], input int cnt,
                           input int lat);
      `CHECK_EQ(beats.size(), cnt)
      for (int i = 0; i < cnt; i++) `CHECK_EQ(beats[i], e[i])
      `CHECK_EQ(bcyc[0] - k0, 2 + lat)
   endtask : chk_read

   initial begin
      i_sys_rst = 1'b1;
      i_clk_gate = 1'b0;
      i_cmd_valid = 1'b0;
      i_cmd = sdram_pkg::CMD_NOP;
      i_bank = 1'b0;
      i_addr = 11'h000;
      i_wdata_valid = 1'b0;
      i_wdata = 16'h0000;
      i_byte_mask = 2'h3;
      repeat (6) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      i_clk_gate <= 1'b1;
      idle(4);
      chk_state(2'h0, 12'h020, sdram_pkg::LP_NONE);
      issue(sdram_pkg::CMD_MODE_SET, 1'b1, 11'h030, 16'h0000, 2'h0);
      idle(2);
      chk_state(2'h0, 12'h830, sdram_pkg::LP_NONE);
      issue(sdram_pkg::CMD_ACTIVATE, 1'b0, 11'h155, 16'h0000, 2'h0);
      issue(sdram_pkg::CMD_ACTIVATE, 1'b1, 11'h2AA, 16'h0000, 2'h0);
      idle(3);
      chk_state(2'h3, 12'h830, sdram_pkg::LP_NONE);
      // Upper column bits must be ignored, so bank 1 uses 11'h305
      issue(sdram_pkg::CMD_WRITE, 1'b0, 11'h005, 16'hA5C3, 2'h0);
      issue(sdram_pkg::CMD_WRITE, 1'b1, 11'h305, 16'h3C5A, 2'h0);
      issue(sdram_pkg::CMD_WRITE, 1'b0, 11'h006, 16'h1234, 2'h0);
      issue(sdram_pkg::CMD_WRITE, 1'b0, 11'h006, 16'h5678, 2'h2);
      idle(2);
      beats.delete();
      bcyc.delete();
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h005, 16'h0000, 2'h0);
      k0 = k;
      issue(sdram_pkg::CMD_READ, 1'b1, 11'h005, 16'h0000, 2'h0);
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h006, 16'h0000, 2'h0);
      idle(6);
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h006, 16'h0000, 2'h2);
      idle(8);
      chk_read('{16'hA5C3, 16'h3C5A, 16'h1278, 16'h0078}, 4, 3);
      issue(sdram_pkg::CMD_PRECHARGE, 1'b0, 11'h000, 16'h0000, 2'h0);
      idle(2);
      chk_state(2'h2, 12'h830, sdram_pkg::LP_NONE);
      issue(sdram_pkg::CMD_PRECHARGE, 1'b0, 11'h400, 16'h0000, 2'h0);
      idle(2);
      chk_state(2'h0, 12'h830, sdram_pkg::LP_NONE);
      issue(sdram_pkg::CMD_MODE_SET, 1'b0, 11'h222, 16'h0000, 2'h0);
      idle(2);
      issue(sdram_pkg::CMD_ACTIVATE, 1'b0, 11'h155, 16'h0000, 2'h0);
      idle(2);
      chk_state(2'h1, 12'h222, sdram_pkg::LP_NONE);
      // Descending order: a burst write would clobber the lower columns
      for (int c = 11; c >= 8; c--)
         issue(sdram_pkg::CMD_WRITE, 1'b0, 11'(c), 16'hB000 | 16'(c),
               2'h0);
      idle(6);
      beats.delete();
      bcyc.delete();
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h009, 16'h0000, 2'h0);
      k0 = k;
      idle(8);
      chk_read('{16'hB009, 16'hB00A, 16'hB00B, 16'hB008}, 4, 2);
      issue(sdram_pkg::CMD_PRECHARGE, 1'b0, 11'h400, 16'h0000, 2'h0);
      idle(2);
      issue(sdram_pkg::CMD_MODE_SET, 1'b0, 11'h22A, 16'h0000, 2'h0);
      idle(2);
      issue(sdram_pkg::CMD_ACTIVATE, 1'b0, 11'h155, 16'h0000, 2'h0);
      idle(2);
      beats.delete();
      bcyc.delete();
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h009, 16'h0000, 2'h0);
      k0 = k;
      idle(8);
      chk_read('{16'hB009, 16'hB008, 16'hB00B, 16'hB00A}, 4, 2);
      beats.delete();
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h008, 16'h0000, 2'h0);
      issue(sdram_pkg::CMD_BURST_STOP, 1'b0, 11'h000, 16'h0000, 2'h0);
      idle(8);
      `CHECK_EQ(beats.size(), 1)
      `CHECK_EQ(beats[0], 16'hB008)
      issue(sdram_pkg::CMD_READ, 1'b0, 11'h408, 16'h0000, 2'h0);
      idle(10);
      chk_state(2'h0, 12'h22A, sdram_pkg::LP_NONE);
      i_clk_gate <= 1'b0;
      idle(4);
      chk_state(2'h0, 12'h22A, sdram_pkg::LP_POWER_DOWN);
      i_clk_gate <= 1'b1;
      idle(4);
      chk_state(2'h0, 12'h22A, sdram_pkg::LP_NONE);
      issue(sdram_pkg::CMD_ACTIVATE, 1'b1, 11'h2AA, 16'h0000, 2'h0);
      idle(2);
      // The timer's own precharge-all must close the open row
      for (n = 0; n < 2000; n++) begin
         @(negedge i_mclk);
         if (o_refresh_busy === 1'b1) begin
            break;
         end
      end
      if (n >= 2000) begin
         fail_count++;
         stop_test();
      end
      `CHECK_EQ(cyc <= `REFRESH_CYCLES + 40, 1'b1)
      `CHECK_EQ(o_ready, 1'b0)
      @(posedge i_mclk);
      idle(6);
      chk_state(2'h0, 12'h22A, sdram_pkg::LP_NONE);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
